// ===== logic/cmtd_top.sv
`timescale 1ns/1ps
module cmtd_top #(
    parameter int SAMPLE_CYC    = cmtd_pkg::SAMPLE_CYC,
    parameter int LP_SAMPLE_CYC = cmtd_pkg::LP_SAMPLE_CYC,
    parameter int FULL_CYC      = cmtd_pkg::FULL_CYC,
    parameter int TIMEOUT_CYC   = cmtd_pkg::TIMEOUT_CYC
) (
    input  wire logic        i_ref_clk,
    input  wire logic        i_nrst,

    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,

    input  wire logic        i_ac_sense_input,
    input  wire logic        i_charge_enable_pin,
    input  wire logic        i_input_supply,
    input  wire logic        i_line_above,
    input  wire logic [1:0]  i_current_limit_select,

    output logic             o_high_node_select,
    output logic             o_low_node_select,
    output logic             o_meas_high,
    output logic      [2:0]  o_ref_sel,

    output logic             o_charge_on,
    output logic             o_wake_mode,
    output logic      [15:0] o_volt_setpoint,
    output logic      [11:0] o_current_setpoint,
    output logic      [4:0]  o_range_flags
);
    import cmtd_pkg::*;

    // APB decode
    logic        setup;
    logic        wr;
    logic        hit;
    logic        wr_volt;
    logic        wr_curr;
    logic        wr_mode;
    logic        wr_alarm;
    logic [31:0] rd_mux;

    // Stored commands and mode
    logic [15:0] volt_ff;
    logic [15:0] curr_ff;
    logic        inhibit_ff;
    logic [15:0] alarm_ff;
    logic        v_fresh_ff;
    logic        i_fresh_ff;
    logic        cmd_valid_ff;
    logic        wake_arm_ff;
    logic [31:0] timer_ff;
    logic        pready_ff;

    cmtd_state_t state_ff;
    cmtd_state_t nxt_state;

    // Status
    cmtd_range_t range;
    logic        range_upd;
    logic [11:0] ceiling;
    logic [11:0] lim_current;
    logic [4:0]  flags;
    logic        present;
    logic        was_present_ff;

    logic        alarm_blocked;
    logic        range_ok;
    logic        permit;
    logic        run_ok;
    logic        volt_nz;
    logic        curr_nz;
    logic        pair;
    logic        timeout;
    logic        wake_to;
    logic        clear_cmd;
    logic        inserted;
    logic        timer_run;

    assign setup    = i_psel && !i_penable;
    assign wr       = i_psel && i_penable && i_pwrite && pready_ff;
    assign wr_volt  = wr && (i_paddr == ADDR_VOLT);
    assign wr_curr  = wr && (i_paddr == ADDR_CURR);
    assign wr_mode  = wr && (i_paddr == ADDR_MODE);
    assign wr_alarm = wr && (i_paddr == ADDR_ALARM);
    assign hit = (i_paddr == ADDR_VOLT) || (i_paddr == ADDR_CURR) ||
                 (i_paddr == ADDR_MODE) || (i_paddr == ADDR_ALARM) ||
                 (i_paddr == ADDR_STATUS) || (i_paddr == ADDR_LIMIT);

    assign rd_mux =
        (i_paddr == ADDR_VOLT)   ? {16'h0000, volt_ff} :
        (i_paddr == ADDR_CURR)   ? {16'h0000, curr_ff} :
        (i_paddr == ADDR_MODE)   ? {31'h0, inhibit_ff} :
        (i_paddr == ADDR_ALARM)  ? {16'h0000, alarm_ff} :
        (i_paddr == ADDR_STATUS) ? {20'h00000, flags, cmd_valid_ff, inhibit_ff,
                                    alarm_blocked, i_ac_sense_input,
                                    o_charge_on, state_ff} :
        (i_paddr == ADDR_LIMIT)  ? {4'h0, ceiling, 4'h0, lim_current} :
                                   32'h0000_0000;

    // Flags: over, chilled, warm fault, under, present
    assign flags = (range == range_under)      ? 5'h07 :
                   (range == range_warm_fault) ? 5'h05 :
                   (range == range_nominal)    ? 5'h01 :
                   (range == range_chilled)    ? 5'h09 : 5'h18; // [R19]
    assign present = flags[0];
    assign inserted = range_upd && present && !was_present_ff;

    assign alarm_blocked = |alarm_ff;
    assign range_ok = (range == range_chilled) || (range == range_nominal) ||
                      (range == range_under); // [R8]
    assign permit = i_ac_sense_input && !alarm_blocked && !inhibit_ff &&
                    range_ok; // [R3] [R9]
    assign run_ok = i_charge_enable_pin && i_input_supply; // [R4] [R5] [R11] [R12]
    assign volt_nz = volt_ff > VOLT_ZERO_MAX; // [R13]
    assign curr_nz = curr_ff != 16'h0000; // [R13]
    assign pair = v_fresh_ff && i_fresh_ff;
    assign timer_run = (state_ff != st_idle) || cmd_valid_ff;
    assign timeout = timer_run && (timer_ff >= 32'(TIMEOUT_CYC - 1)); // [R7]
    assign wake_to = timeout && ((range == range_chilled) ||
                                 (range == range_under));
    assign clear_cmd = wr_mode && i_pwdata[MODE_CLEAR_BIT]; // [R10]

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            st_idle: begin
                if (cmd_valid_ff && volt_nz && curr_nz && permit) begin
                    nxt_state = st_ctrl; // [R6] [R9] [R11] [R12]
                end else if (wake_arm_ff && !cmd_valid_ff && permit) begin
                    nxt_state = st_wake; // [R1]
                end
            end
            st_wake: begin
                if (pair) begin
                    nxt_state = st_ctrl; // [R2]
                end else if (!permit || wake_to) begin
                    nxt_state = st_idle; // [R3]
                end
            end
            st_ctrl: begin
                if (!permit || timeout || !volt_nz || !curr_nz) begin
                    nxt_state = st_idle; // [R7] [R8] [R9] [R10] [R13]
                end
            end
            default: nxt_state = st_idle;
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            pready_ff <= 1'b0;
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata  <= 32'h0000_0000;
        end else begin
            pready_ff <= setup;
            o_pready  <= setup;
            o_pslverr <= setup && !hit;
            o_prdata  <= setup && !i_pwrite ? rd_mux : 32'h0000_0000;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            volt_ff    <= 16'h0000;
            curr_ff    <= 16'h0000;
            inhibit_ff <= 1'b0;
            alarm_ff   <= 16'h0000;
        end else begin
            if (wr_volt) begin
                volt_ff <= i_pwdata[15:0];
            end else if (clear_cmd) begin
                volt_ff <= 16'h0000; // [R10]
            end
            if (wr_curr) begin
                curr_ff <= i_pwdata[15:0];
            end else if (clear_cmd) begin
                curr_ff <= 16'h0000; // [R10]
            end
            if (wr_mode) begin
                inhibit_ff <= i_pwdata[MODE_INHIBIT_BIT]; // [R9]
            end
            if (wr_alarm) begin
                alarm_ff <= i_pwdata[15:0] & ALARM_MASK; // [R3]
            end
        end
    end

    // A write in the cycle a pair is consumed stays fresh
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            v_fresh_ff   <= 1'b0;
            i_fresh_ff   <= 1'b0;
            cmd_valid_ff <= 1'b0;
            timer_ff     <= 32'h0;
        end else begin
            v_fresh_ff <= wr_volt || (v_fresh_ff && !pair);
            i_fresh_ff <= wr_curr || (i_fresh_ff && !pair);
            if (pair) begin
                cmd_valid_ff <= 1'b1;
            end else if (timeout || clear_cmd) begin
                cmd_valid_ff <= 1'b0; // [R7]
            end
            // Enable pin and supply never touch the timer
            if (pair || !timer_run || timeout) begin
                timer_ff <= 32'h0; // [R22] [R4] [R5]
            end else begin
                timer_ff <= timer_ff + 32'h1;
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            state_ff       <= st_idle;
            wake_arm_ff    <= 1'b0;
            was_present_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            if (range_upd) begin
                was_present_ff <= present;
            end
            if (inserted) begin
                wake_arm_ff <= 1'b1; // [R1]
            end else if (!present || (state_ff != st_idle && nxt_state != st_wake)) begin
                wake_arm_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            o_charge_on        <= 1'b0;
            o_wake_mode        <= 1'b0;
            o_volt_setpoint    <= 16'h0000;
            o_current_setpoint <= 12'h000;
            o_range_flags      <= 5'h18;
        end else begin
            o_charge_on <= (state_ff != st_idle) && run_ok; // [R4] [R5] [R11] [R12]
            o_wake_mode <= state_ff == st_wake;
            o_volt_setpoint <= (state_ff == st_ctrl && run_ok) ? volt_ff : 16'h0000;
            if (!run_ok || state_ff == st_idle) begin
                o_current_setpoint <= 12'h000;
            end else if (state_ff == st_wake) begin
                o_current_setpoint <= WAKE_MA;
            end else begin
                o_current_setpoint <= lim_current; // [R21]
            end
            o_range_flags <= flags; // [R19]
        end
    end

    cmtd_seq #(
        .SAMPLE_CYC    (SAMPLE_CYC),
        .LP_SAMPLE_CYC (LP_SAMPLE_CYC),
        .FULL_CYC      (FULL_CYC)
    ) u_seq (
        .i_ref_clk          (i_ref_clk),
        .i_nrst             (i_nrst),
        .i_ac_present       (i_ac_sense_input),
        .i_line_above       (i_line_above),
        .o_high_node_select (o_high_node_select),
        .o_low_node_select  (o_low_node_select),
        .o_meas_high        (o_meas_high),
        .o_ref_sel          (o_ref_sel),
        .o_range            (range),
        .o_update           (range_upd)
    );

    cmtd_current_limit_select u_current_limit_select (
        .i_ref_clk              (i_ref_clk),
        .i_nrst                 (i_nrst),
        .i_current_limit_select (i_current_limit_select),
        .i_cmd                  (curr_ff),
        .o_ceiling              (ceiling),
        .o_current              (lim_current)
    );
endmodule : cmtd_top

// ===== logic/cmtd_pkg.sv
// How it works
// R1: fresh battery without commands starts wake charging
// R2: both commands written moves wake to controlled
// R3: AC loss, alarm, inhibit end wake charging
// R4: enable pin low suspends wake, timer untouched
// R5: low input supply suspends wake, timer untouched
// R6: controlled start needs nonzero commands, range, AC
// R7: commands not rewritten in time stop charging
// R8: over or warm fault range stops charging
// R9: AC, alarm, inhibit stop; uninhibit resumes stored
// R10: clear setpoints bit stops controlled charging
// R11: enable pin low stops, release resumes stored
// R12: low input supply stops, recovery resumes stored
// R13: zero voltage or current command stops charging
// R14: with AC sample line every period
// R15: thresholds tested top down, stop when found
// R16: threshold shifted by previous range for hysteresis
// R17: upper tests drive high node, lower drive low
// R18: without AC slow samples, periodic full evaluation
// R19: range decodes to status flags per table
// R20: limit select picks one of four ceilings
// R21: ceiling caps every written current command
// R22: fresh pair of commands restarts timeout timer
package cmtd_pkg;
    localparam int CLK_HZ        = 10_000_000;
    localparam int CYC_PER_MS    = CLK_HZ / 1000;
    localparam int SAMPLE_MS     = 32;
    localparam int SAMPLE_CYC    = SAMPLE_MS * CYC_PER_MS;
    localparam int LP_SAMPLE_MS  = 250;
    localparam int LP_SAMPLE_CYC = LP_SAMPLE_MS * CYC_PER_MS;
    localparam int FULL_MS       = 30000;
    localparam int FULL_CYC      = FULL_MS * CYC_PER_MS;
    localparam int TIMEOUT_MS    = 175000;
    localparam int TIMEOUT_CYC   = TIMEOUT_MS * CYC_PER_MS;
    localparam int SETTLE_US     = 100;
    localparam int SETTLE_CYC    = SETTLE_US * (CLK_HZ / 1_000_000);

    localparam logic [7:0] ADDR_VOLT   = 8'h00;
    localparam logic [7:0] ADDR_CURR   = 8'h04;
    localparam logic [7:0] ADDR_MODE   = 8'h08;
    localparam logic [7:0] ADDR_ALARM  = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_LIMIT  = 8'h14;

    localparam int MODE_INHIBIT_BIT = 0;
    localparam int MODE_CLEAR_BIT   = 1;
    localparam logic [15:0] ALARM_MASK    = 16'hF000;
    localparam logic [15:0] VOLT_ZERO_MAX = 16'h049F;
    localparam logic [11:0] WAKE_MA       = 12'h050;

    localparam logic [11:0] LIM_SHORT = 12'h3FF;
    localparam logic [11:0] LIM_10K   = 12'h7FE;
    localparam logic [11:0] LIM_33K   = 12'hBFC;
    localparam logic [11:0] LIM_OPEN  = 12'hFFC;
    localparam logic [11:0] GRAIN_1MA = 12'hFFF;
    localparam logic [11:0] GRAIN_2MA = 12'hFFE;
    localparam logic [11:0] GRAIN_4MA = 12'hFFC;

    typedef enum logic [2:0] {
        range_under      = 3'h0,
        range_warm_fault = 3'h1,
        range_nominal    = 3'h2,
        range_chilled    = 3'h3,
        range_over       = 3'h4
    } cmtd_range_t;

    typedef enum logic [1:0] {
        st_idle = 2'h0,
        st_wake = 2'h1,
        st_ctrl = 2'h3
    } cmtd_state_t;
endpackage : cmtd_pkg

// ===== logic/cmtd_current_limit_select.sv
`timescale 1ns/1ps
module cmtd_current_limit_select (
    input  wire logic        i_ref_clk,
    input  wire logic        i_nrst,
    input  wire logic [1:0]  i_current_limit_select,
    input  wire logic [15:0] i_cmd,
    output logic      [11:0] o_ceiling,
    output logic      [11:0] o_current
);
    import cmtd_pkg::*;

    logic [11:0] ceil_w;
    logic [11:0] grain_w;
    logic [11:0] nxt_current;

    // Short, 10k, 33k, open
    assign ceil_w = (i_current_limit_select == 2'h0) ? LIM_SHORT :
                    (i_current_limit_select == 2'h1) ? LIM_10K :
                    (i_current_limit_select == 2'h2) ? LIM_33K : LIM_OPEN; // [R20]
    assign grain_w = (i_current_limit_select == 2'h0) ? GRAIN_1MA :
                     (i_current_limit_select == 2'h1) ? GRAIN_2MA : GRAIN_4MA; // [R20]
    assign nxt_current = (i_cmd > {4'h0, ceil_w}) ? ceil_w
                       : (i_cmd[11:0] & grain_w); // [R21]

    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            o_ceiling <= 12'h000;
            o_current <= 12'h000;
        end else begin
            o_ceiling <= ceil_w;
            o_current <= nxt_current;
        end
    end
endmodule : cmtd_current_limit_select

// ===== logic/cmtd_seq.sv
`timescale 1ns/1ps
module cmtd_seq #(
    parameter int SAMPLE_CYC    = cmtd_pkg::SAMPLE_CYC,
    parameter int LP_SAMPLE_CYC = cmtd_pkg::LP_SAMPLE_CYC,
    parameter int FULL_CYC      = cmtd_pkg::FULL_CYC
) (
    input  wire logic         i_ref_clk,
    input  wire logic         i_nrst,
    input  wire logic         i_ac_present,
    input  wire logic         i_line_above,
    output logic              o_high_node_select,
    output logic              o_low_node_select,
    output logic              o_meas_high,
    output logic [2:0]        o_ref_sel,
    output cmtd_pkg::cmtd_range_t o_range,
    output logic              o_update
);
    import cmtd_pkg::*;

    logic [31:0] per_ff;
    logic [31:0] full_ff;
    logic [31:0] settle_ff;
    logic        busy_ff;
    logic        part_ff;
    logic [1:0]  step_ff;
    logic        nxt_busy;
    logic [1:0]  nxt_step;
    logic [31:0] period;
    logic        start;
    logic        sample;
    logic        done;
    logic [2:0]  upper;

    assign period = i_ac_present ? 32'(SAMPLE_CYC) : 32'(LP_SAMPLE_CYC); // [R14] [R18]
    assign start  = !busy_ff && (per_ff >= period - 32'h1);
    assign sample = busy_ff && (settle_ff == 32'(SETTLE_CYC - 1));
    assign upper  = 3'h4 - {1'b0, step_ff};
    // Partial check stops after the over test unless the last range was over and the line reads below
    assign done = sample && (i_line_above || step_ff == 2'h3 ||
                  (part_ff && ((o_range == range_over) == i_line_above))); // [R15] [R18]
    assign nxt_busy = start || (busy_ff && !done);
    assign nxt_step = start ? 2'h0 : (sample && !done) ? step_ff + 2'h1 : step_ff;

    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            per_ff    <= 32'h0;
            full_ff   <= 32'h0;
            settle_ff <= 32'h0;
            busy_ff   <= 1'b0;
            part_ff   <= 1'b0;
            step_ff   <= 2'h0;
            o_range   <= range_over;
            o_update  <= 1'b0;
            o_ref_sel <= 3'h0;
            o_meas_high        <= 1'b0;
            o_high_node_select <= 1'b0;
            o_low_node_select  <= 1'b0;
        end else begin
            per_ff    <= start ? 32'h0 : per_ff + 32'h1;
            busy_ff   <= nxt_busy;
            step_ff   <= nxt_step;
            settle_ff <= (start || sample) ? 32'h0 : settle_ff + 32'h1;
            if (start) begin
                part_ff <= !i_ac_present && (full_ff < 32'(FULL_CYC - 1)); // [R18]
                full_ff <= (!i_ac_present && full_ff < 32'(FULL_CYC - 1)) ?
                           full_ff + period : 32'h0;
            end
            if (done) begin
                o_range <= i_line_above ? cmtd_range_t'(upper) :
                           (step_ff == 2'h3) ? range_under : o_range; // [R15]
            end
            o_update <= done;
            // Threshold moves toward the side the line sat on last time
            o_ref_sel <= {o_range >= (3'h4 - {1'b0, nxt_step}), nxt_step}; // [R16]
            o_high_node_select <= nxt_busy && !nxt_step[1]; // [R17]
            o_low_node_select  <= nxt_busy && nxt_step[1]; // [R17]
            o_meas_high        <= nxt_step[1]; // [R17]
        end
    end
endmodule : cmtd_seq

// ===== sim/cmtd_top_monitor.sv
`timescale 1ns/1ps
module cmtd_top_mon (
    input wire logic        i_ref_clk,
    input wire logic        i_nrst,
    input wire logic        i_ac_sense_input,
    input wire logic        i_charge_enable_pin,
    input wire logic        i_input_supply,
    input wire logic [1:0]  i_current_limit_select,
    input wire logic        o_high_node_select,
    input wire logic        o_low_node_select,
    input wire logic        o_meas_high,
    input wire logic [2:0]  o_ref_sel,
    input wire logic        o_charge_on,
    input wire logic        o_wake_mode,
    input wire logic [15:0] o_volt_setpoint,
    input wire logic [11:0] o_current_setpoint,
    input wire logic [4:0]  o_range_flags
);
    import cmtd_pkg::*;
    wire logic [1:0]  lsel = i_current_limit_select;
    wire logic [11:0] ceil = (lsel == 2'h0) ? 12'h3FF : (lsel == 2'h1) ? 12'h7FE :
                             (lsel == 2'h2) ? 12'hBFC : 12'hFFC;
    wire logic [11:0] grain = (lsel == 2'h0) ? 12'hFFF : (lsel == 2'h1) ? 12'hFFE : 12'hFFC;

    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_nrst);

    a_flags_legal: assert property (
        o_range_flags inside {5'h07, 5'h05, 5'h01, 5'h09, 5'h18})
        else $error("illegal range flags");
    a_ac_stops: assert property ((!i_ac_sense_input)[*4] |-> !o_charge_on)
        else $error("charging without AC");
    a_pin_stops: assert property ((!i_charge_enable_pin)[*4] |-> !o_charge_on)
        else $error("charging with enable pin low");
    a_supply_stops: assert property ((!i_input_supply)[*4] |-> !o_charge_on)
        else $error("charging on low supply");
    a_hot_stops: assert property (
        o_range_flags == 5'h05 || o_range_flags[4] |=> !o_charge_on)
        else $error("charging in hot or over range");
    a_ceiling_holds: assert property (
        lsel == $past(lsel, 3) |-> o_current_setpoint <= ceil)
        else $error("current above ceiling");
    a_grain_kept: assert property (
        !o_wake_mode && lsel == $past(lsel, 3) |-> (o_current_setpoint & ~grain) == 12'h000)
        else $error("current off grain");
    a_node_order: assert property (
        o_high_node_select |-> !o_low_node_select && !o_meas_high && !o_ref_sel[1])
        else $error("upper step drive wrong");
    a_start_volt: assert property (
        $rose(o_charge_on) && !o_wake_mode |-> o_volt_setpoint > VOLT_ZERO_MAX)
        else $error("started with zero voltage");
    a_wake_current: assert property (
        o_wake_mode && o_charge_on |-> o_current_setpoint == WAKE_MA)
        else $error("wake current wrong");
endmodule : cmtd_top_mon

bind cmtd_top cmtd_top_mon u_mon (
    .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_ac_sense_input(i_ac_sense_input),
    .i_charge_enable_pin(i_charge_enable_pin), .i_input_supply(i_input_supply),
    .i_current_limit_select(i_current_limit_select), .o_high_node_select(o_high_node_select),
    .o_low_node_select(o_low_node_select), .o_meas_high(o_meas_high), .o_ref_sel(o_ref_sel),
    .o_charge_on(o_charge_on), .o_wake_mode(o_wake_mode), .o_volt_setpoint(o_volt_setpoint),
    .o_current_setpoint(o_current_setpoint), .o_range_flags(o_range_flags)
);

// ===== sim/cmtd_therm_model.sv
`timescale 1ns/1ps
module cmtd_therm_model (
    input  wire logic                  i_ref_clk,
    input  wire logic                  i_nrst,
    input  wire logic                  i_high_node_select,
    input  wire logic                  i_low_node_select,
    input  wire logic [2:0]            i_ref_sel,
    input  wire cmtd_pkg::cmtd_range_t i_range,
    output logic                       o_line_above
);
    import cmtd_pkg::*;
    logic toggle_ff;
    wire logic driven = i_high_node_select | i_low_node_select;
    // Step k reads above when battery range is at least 4 - k
    wire logic above = ({1'b0, i_range} + {2'b00, i_ref_sel[1:0]}) >= 4'h4;
    // Unpowered divider gives no steady level
    always_ff @(posedge i_ref_clk) begin
        if (!i_nrst) begin
            toggle_ff <= 1'b0;
        end else begin
            toggle_ff <= !toggle_ff;
        end
    end
    assign o_line_above = driven ? above : toggle_ff;
endmodule : cmtd_therm_model

// ===== sim/cmtd_top_tb.sv
`timescale 1ns/1ps
module cmtd_top_tb;
    import cmtd_pkg::*;
    logic        clk, nrst, psel, penable, pwrite, ac, pin, supply, err;
    logic        pready, pslverr, line, hsel, lsel, mhigh, on, wake;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [2:0]  rsel;
    logic [1:0]  limsel;
    logic [15:0] volt;
    logic [11:0] cur;
    logic [4:0]  flags;
    cmtd_range_t rng;
    int          fail_count, compares;
    logic [11:0] lims [4] = '{12'h3FF, 12'h7FE, 12'hBFC, 12'hFFC};

    cmtd_top #(.SAMPLE_CYC(4500), .LP_SAMPLE_CYC(5000), .FULL_CYC(15000),
        .TIMEOUT_CYC(20000)) DUT (
        .i_ref_clk(clk), .i_nrst(nrst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_ac_sense_input(ac), .i_charge_enable_pin(pin),
        .i_input_supply(supply), .i_line_above(line), .i_current_limit_select(limsel),
        .o_high_node_select(hsel), .o_low_node_select(lsel), .o_meas_high(mhigh),
        .o_ref_sel(rsel), .o_charge_on(on), .o_wake_mode(wake), .o_volt_setpoint(volt),
        .o_current_setpoint(cur), .o_range_flags(flags));
    cmtd_therm_model u_bat (.i_ref_clk(clk), .i_nrst(nrst), .i_high_node_select(hsel),
        .i_low_node_select(lsel), .i_ref_sel(rsel), .i_range(rng), .o_line_above(line));

    always #50 clk = ~clk;

    task final_report;
        $display("comparisons %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report

    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task hang(input string name);
        fail_count++;
        $display("mismatch %s expected done seen timeout", name);
        final_report();
    endtask : hang

    task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            n++;
            if (n > 50) hang("pready");
            @(posedge clk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wr(input logic [7:0] a, input logic [15:0] d);
        apb(a, 1'b1, {16'h0000, d});
    endtask : wr

    task pair(input logic [15:0] v, input logic [15:0] i);
        wr(ADDR_VOLT, v);
        wr(ADDR_CURR, i);
        repeat (4) @(posedge clk);
    endtask : pair

    task expect_on(input logic e);
        int n;
        n = 0;
        while (on !== e) begin
            n++;
            if (n > 40) hang("charge_on");
            @(negedge clk);
        end
        check("charge_on", 32'(on), 32'(e));
    endtask : expect_on

    task wait_flags(input logic [4:0] e);
        int n;
        n = 0;
        while (flags !== e) begin
            n++;
            if (n > 12000) hang("range_flags");
            @(negedge clk);
        end
        check("range_flags", 32'(flags), 32'(e));
    endtask : wait_flags

    initial begin
        clk = 1'b0;
        nrst = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {ac, pin, supply} = 3'h7;
        limsel = 2'h1;
        rng = range_over;
        fail_count = 0;
        compares = 0;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        apb(ADDR_STATUS, 1'b0, 32'h0);
        check("status", rd, 32'h0000_0C08);
        apb(8'h18, 1'b0, 32'h0);
        check("slverr", 32'(err), 32'h1);
        check("unmapped", rd, 32'h0);
        rng <= range_nominal;
        wait_flags(5'h01);
        expect_on(1'b1);
        check("wake", 32'(wake), 32'h1);
        check("wake_cur", 32'(cur), 32'h050);
        @(posedge clk);
        pin <= 1'b0;
        expect_on(1'b0);
        check("wake_kept", 32'(wake), 32'h1);
        repeat (4) @(posedge clk);
        pin <= 1'b1;
        expect_on(1'b1);
        @(posedge clk);
        supply <= 1'b0;
        expect_on(1'b0);
        repeat (4) @(posedge clk);
        supply <= 1'b1;
        expect_on(1'b1);
        pair(16'h3000, 16'h0900);
        check("wake_left", 32'(wake), 32'h0);
        check("volt", 32'(volt), 32'h3000);
        check("clamped", 32'(cur), 32'h7FE);
        wr(ADDR_MODE, 16'h0001);
        expect_on(1'b0);
        wr(ADDR_MODE, 16'h0000);
        expect_on(1'b1);
        check("volt_kept", 32'(volt), 32'h3000);
        wr(ADDR_ALARM, 16'h1000);
        expect_on(1'b0);
        wr(ADDR_ALARM, 16'h0000);
        expect_on(1'b1);
        @(posedge clk);
        ac <= 1'b0;
        expect_on(1'b0);
        repeat (4) @(posedge clk);
        ac <= 1'b1;
        expect_on(1'b1);
        wr(ADDR_VOLT, 16'h0400);
        expect_on(1'b0);
        pair(16'h3000, 16'h0123);
        expect_on(1'b1);
        check("grain", 32'(cur), 32'h122);
        rng <= range_warm_fault;
        wait_flags(5'h05);
        expect_on(1'b0);
        rng <= range_nominal;
        wait_flags(5'h01);
        expect_on(1'b1);
        pair(16'h3000, 16'h0100);
        repeat (15000) @(posedge clk);
        pair(16'h3000, 16'h0100);
        repeat (15000) @(posedge clk);
        expect_on(1'b1);
        repeat (6000) @(posedge clk);
        expect_on(1'b0);
        pair(16'h3000, 16'h0100);
        expect_on(1'b1);
        wr(ADDR_MODE, 16'h0002);
        expect_on(1'b0);
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            limsel <= k[1:0];
            repeat (4) @(posedge clk);
            apb(ADDR_LIMIT, 1'b0, 32'h0);
            check("ceiling", 32'(rd[27:16]), 32'(lims[k]));
        end
        final_report();
    end
endmodule : cmtd_top_tb
